// >>> eac_pkg.sv
// constants and types for the acknowledge-driven wait and termination logic
// assumes one system bus clock and configuration that holds still during an access
package eac_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int TIMEOUT_CYC = 1024;
   localparam int TO_W = 11;
   localparam logic [TO_W-1:0] TO_LAST = 11'(TIMEOUT_CYC - 1);
   localparam logic [5:0] INSENS_BASE = 6'h02;
   localparam logic [5:0] INSENS_MAX = 6'h05;
   // ----------------------------------------------------------------
   // chip selects and field values
   // ----------------------------------------------------------------
   localparam logic [2:0] EDGE_CS = 3'h5;
   localparam logic [2:0] SHARED_CS = 3'h4;
   localparam logic [5:0] EDGE_WAIT_CNT = 6'h3F;
   localparam logic [5:0] ONE_CYC = 6'h01;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ASSERT = 5'h02,
      ST_INSENS = 5'h04,
      ST_ACCESS = 5'h08,
      ST_NEGATE = 5'h10
   } eac_state_type;
   typedef enum logic [2:0] {
      MODE_PLAIN = 3'h1,
      MODE_EDGE = 3'h2,
      MODE_LEVEL = 3'h4
   } eac_mode_type;
endpackage

// >>> eac_mon_if.sv
// signals between the access sequencer and the ack monitor
// assumes both ends run on the system bus clock
`timescale 1ns/1ps
`default_nettype none
interface eac_mon_if;
   logic clear;
   logic run;
   logic ack_in;
   logic ack_rise;
   logic timeout;
   modport ctl(output clear, output run, output ack_in, input ack_rise, input timeout);
   modport mon(input clear, input run, input ack_in, output ack_rise, output timeout);
endinterface
`default_nettype wire

// >>> eac_ack_mon.sv
// ack edge detector and bus time-out counter
// assumes ack is already synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module eac_ack_mon (
   input wire logic clk_i,
   input wire logic rst_i,
   eac_mon_if.mon mon
);
   import eac_pkg::*;
   logic prev_ack_ff;
   logic nxt_prev_ack;
   logic [TO_W-1:0] to_cnt_ff;
   logic [TO_W-1:0] nxt_to_cnt;

   // ----------------------------------------------------------------
   // edge and time-out
   // ----------------------------------------------------------------
   // previous level tracked every cycle, so an edge in the gap is not seen later as a new one
   assign mon.ack_rise = mon.ack_in & ~prev_ack_ff;
   assign mon.timeout = mon.run && (to_cnt_ff == TO_LAST);

   always_comb begin
      nxt_prev_ack = mon.ack_in;
      nxt_to_cnt = to_cnt_ff;
      if (mon.clear) begin
         nxt_to_cnt = '0;
      end else if (mon.run && !mon.timeout) begin
         nxt_to_cnt = to_cnt_ff + 11'h001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_ack_ff <= 1'b1;
         to_cnt_ff <= '0;
      end else begin
         prev_ack_ff <= nxt_prev_ack;
         to_cnt_ff <= nxt_to_cnt;
      end
   end

   cnt_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
      mon.run && !mon.clear |=> to_cnt_ff <= TO_LAST)
      else $error("time-out counter ran past its limit");
endmodule
`default_nettype wire

// >>> eac_ack_ctrl.sv
// acknowledge-driven access sequencer for one external bus cycle at a time
// assumes req_i is a one-cycle request and config holds stable while busy_o is high
`timescale 1ns/1ps
`default_nettype none
module eac_ack_ctrl (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_i,
   input wire logic [2:0] cs_index_i,
   input wire logic sync_mode_i,
   input wire logic [5:0] wait_state_count_i,
   input wire logic [3:0] chip_select_assert_delay_i,
   input wire logic [3:0] chip_select_negate_delay_i,
   input wire logic ack_wait_enable_i,
   input wire logic ack_edge_mode_enable_i,
   input wire logic [1:0] ack_insensitivity_time_i,
   input wire logic transfer_ack_input_i,
   output logic busy_o,
   output logic cs_active_o,
   output logic stalled_o,
   output logic done_o,
   output logic bus_error_o
);
   import eac_pkg::*;

   eac_state_type state_ff, nxt_state;
   eac_mode_type mode_ff, nxt_mode;
   logic [5:0] cnt_ff, nxt_cnt;
   logic [5:0] wait_ff, nxt_wait;
   logic [5:0] ins_ff, nxt_ins;
   logic [5:0] gap_ff, nxt_gap;
   logic [2:0] cs_ff, nxt_cs;
   logic busy_ff, nxt_busy;
   logic cs_act_ff, nxt_cs_act;
   logic stall_ff, nxt_stall;
   logic done_ff, nxt_done;
   logic err_ff, nxt_err;
   logic ack;

   eac_mon_if mon_if();

   eac_ack_mon u_mon (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .mon(mon_if.mon)
   );

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // state that follows the assert delay
   function automatic eac_state_type after_assert(input eac_mode_type m);
      after_assert = (m == MODE_LEVEL) ? ST_INSENS : ST_ACCESS;
   endfunction

   function automatic logic ack_used(input eac_mode_type m);
      ack_used = (m != MODE_PLAIN);
   endfunction

   assign ack = transfer_ack_input_i;
   assign mon_if.ack_in = ack;
   assign mon_if.clear = (state_ff == ST_IDLE);
   // time-out covers the whole cycle up to termination, not the negate gap
   assign mon_if.run = ack_used(mode_ff) && (state_ff != ST_IDLE)
      && (state_ff != ST_NEGATE);

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_mode = mode_ff;
      nxt_cnt = cnt_ff;
      nxt_wait = wait_ff;
      nxt_ins = ins_ff;
      nxt_gap = gap_ff;
      nxt_cs = cs_ff;
      nxt_done = 1'b0;
      nxt_err = 1'b0;
      unique case (state_ff)
         ST_IDLE: begin
            if (req_i) begin
               nxt_cs = cs_index_i;
               // sync accesses never look at ack
               if (sync_mode_i) begin
                  nxt_mode = MODE_PLAIN;
               end else if (ack_edge_mode_enable_i && cs_index_i == EDGE_CS) begin
                  nxt_mode = MODE_EDGE;
               end else if (ack_wait_enable_i && !ack_edge_mode_enable_i
                     && cs_index_i != SHARED_CS) begin
                  nxt_mode = MODE_LEVEL;
               end else begin
                  nxt_mode = MODE_PLAIN;
               end
               nxt_wait = (wait_state_count_i == 6'h00) ? ONE_CYC : wait_state_count_i;
               nxt_ins = {4'h0, ack_insensitivity_time_i} + INSENS_BASE;
               nxt_gap = {2'h0, chip_select_negate_delay_i};
               // edge mode always keeps at least one idle gap for the next edge
               if (nxt_mode == MODE_EDGE && nxt_gap == 6'h00) begin
                  nxt_gap = ONE_CYC;
               end
               if (chip_select_assert_delay_i != 4'h0) begin
                  nxt_state = ST_ASSERT;
                  nxt_cnt = {2'h0, chip_select_assert_delay_i};
               end else begin
                  nxt_state = after_assert(nxt_mode);
                  nxt_cnt = (nxt_mode == MODE_LEVEL) ? nxt_ins : nxt_wait;
               end
            end
         end
         ST_ASSERT: begin
            if (cnt_ff <= ONE_CYC) begin
               nxt_state = after_assert(mode_ff);
               nxt_cnt = (mode_ff == MODE_LEVEL) ? ins_ff : wait_ff;
            end else begin
               nxt_cnt = cnt_ff - ONE_CYC;
            end
         end
         ST_INSENS: begin
            // ack is not looked at while the window runs
            if (cnt_ff <= ONE_CYC) begin
               nxt_state = ST_ACCESS;
               nxt_cnt = wait_ff;
            end else begin
               nxt_cnt = cnt_ff - ONE_CYC;
            end
         end
         ST_ACCESS: begin
            if (mode_ff == MODE_EDGE) begin
               if (mon_if.ack_rise) begin
                  nxt_done = 1'b1;
                  nxt_state = ST_NEGATE;
                  nxt_cnt = gap_ff;
               end
            end else if (mode_ff == MODE_LEVEL && !ack) begin
               nxt_cnt = cnt_ff;
            end else if (cnt_ff <= ONE_CYC) begin
               nxt_done = 1'b1;
               nxt_state = (gap_ff == 6'h00) ? ST_IDLE : ST_NEGATE;
               nxt_cnt = gap_ff;
            end else begin
               nxt_cnt = cnt_ff - ONE_CYC;
            end
         end
         ST_NEGATE: begin
            if (cnt_ff <= ONE_CYC) begin
               nxt_state = ST_IDLE;
            end else begin
               nxt_cnt = cnt_ff - ONE_CYC;
            end
         end
      endcase
      // time-out wins over a late ack and aborts at once
      if (mon_if.timeout) begin
         nxt_done = 1'b0;
         nxt_err = 1'b1;
         nxt_state = ST_IDLE;
         nxt_cnt = 6'h00;
      end
      nxt_busy = (nxt_state != ST_IDLE);
      nxt_cs_act = (nxt_state == ST_INSENS) || (nxt_state == ST_ACCESS);
      // next mode, so a stale level mode cannot flag a stall on a new plain access
      nxt_stall = (nxt_state == ST_ACCESS) && (nxt_mode == MODE_LEVEL) && !ack
         && !mon_if.timeout;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
         mode_ff <= MODE_PLAIN;
         cnt_ff <= 6'h00;
         wait_ff <= ONE_CYC;
         ins_ff <= INSENS_BASE;
         gap_ff <= 6'h00;
         cs_ff <= 3'h0;
         busy_ff <= 1'b0;
         cs_act_ff <= 1'b0;
         stall_ff <= 1'b0;
         done_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         mode_ff <= nxt_mode;
         cnt_ff <= nxt_cnt;
         wait_ff <= nxt_wait;
         ins_ff <= nxt_ins;
         gap_ff <= nxt_gap;
         cs_ff <= nxt_cs;
         busy_ff <= nxt_busy;
         cs_act_ff <= nxt_cs_act;
         stall_ff <= nxt_stall;
         done_ff <= nxt_done;
         err_ff <= nxt_err;
      end
   end

   assign busy_o = busy_ff;
   assign cs_active_o = cs_act_ff;
   assign stalled_o = stall_ff;
   assign done_o = done_ff;
   assign bus_error_o = err_ff;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // helper: length of the insensitivity window just spent
   logic [5:0] ins_len_ff;
   logic [5:0] nxt_ins_len;
   always_comb begin
      nxt_ins_len = 6'h00;
      if (state_ff == ST_INSENS) begin
         nxt_ins_len = ins_len_ff + ONE_CYC;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ins_len_ff <= 6'h00;
      end else begin
         ins_len_ff <= nxt_ins_len;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   timeout_err_a: assert property (mon_if.timeout |=> bus_error_o && !done_o)
      else $error("time-out did not raise a bus error");
   abort_cs_a: assert property (bus_error_o |-> !cs_active_o && !busy_o)
      else $error("chip select still active after a bus error");
   edge_end_a: assert property (state_ff == ST_ACCESS && mode_ff == MODE_EDGE
      && mon_if.ack_rise && !mon_if.timeout |=> done_o ##1 !done_o)
      else $error("edge ack did not end the transfer");
   edge_cs5_a: assert property (mode_ff == MODE_EDGE && busy_o |-> cs_ff == EDGE_CS)
      else $error("edge mode on a chip select other than 5");
   level_cs_a: assert property (mode_ff == MODE_LEVEL && busy_o |-> cs_ff != SHARED_CS)
      else $error("level mode on the shared chip select");
   sync_plain_a: assert property (state_ff == ST_IDLE && req_i && sync_mode_i
      |=> mode_ff == MODE_PLAIN)
      else $error("synchronous access used the ack");
   edge_gap_a: assert property (done_o && mode_ff == MODE_EDGE
      |-> state_ff == ST_NEGATE && busy_o)
      else $error("no gap after an edge-terminated transfer");
   insens_len_a: assert property ($past(state_ff == ST_INSENS) && state_ff == ST_ACCESS
      |-> ins_len_ff >= INSENS_BASE && ins_len_ff <= INSENS_MAX && ins_len_ff == ins_ff)
      else $error("insensitivity window length wrong");
   level_stall_a: assert property (state_ff == ST_ACCESS && mode_ff == MODE_LEVEL
      && !ack && !mon_if.timeout |=> state_ff == ST_ACCESS && !done_o && stalled_o)
      else $error("level access not suspended while ack low");
   level_go_a: assert property (state_ff == ST_ACCESS && mode_ff == MODE_LEVEL && ack
      && !mon_if.timeout && cnt_ff > ONE_CYC |=> cnt_ff == $past(cnt_ff) - ONE_CYC)
      else $error("wait states did not advance with ack high");

   edge_done_c: cover property (done_o && mode_ff == MODE_EDGE);
   level_stall_c: cover property (stalled_o ##1 !stalled_o && busy_o);
   timeout_c: cover property (bus_error_o);
endmodule
`default_nettype wire

// >>> eac_ack_dev.sv
// external device model that answers each access on the ack pin
// assumes the ack pin has a pull-up, so a deselected device leaves it high
`timescale 1ns/1ps
`default_nettype none
module eac_ack_dev (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cs_active_i,
   input wire logic [10:0] low_cyc_i,
   output logic ack_o
);
   logic cs_ff;
   logic nxt_cs;
   logic [10:0] cnt_ff;
   logic [10:0] nxt_cnt;
   // ----------------------------------------------------------------
   // hold ack low for a set time after select
   // ----------------------------------------------------------------
   always_comb begin
      nxt_cs = cs_active_i;
      nxt_cnt = cnt_ff;
      if (!cs_active_i) begin
         nxt_cnt = 11'h000; // released: pull-up wins
      end else if (!cs_ff) begin
         nxt_cnt = low_cyc_i; // 0 means ready at once, no edge produced
      end else if (cnt_ff != 11'h000) begin
         nxt_cnt = cnt_ff - 11'h001;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cs_ff <= 1'h0;
         cnt_ff <= 11'h000;
      end else begin
         cs_ff <= nxt_cs;
         cnt_ff <= nxt_cnt;
      end
   end
   // low-to-high return is the edge an edge-mode access waits on
   assign ack_o = (cnt_ff == 11'h000);
endmodule
`default_nettype wire

// >>> eac_ack_ctrl_tb.sv
// self-checking bench for the ack wait and termination sequencer
// assumes the device model above stands on the ack pin
`timescale 1ns/1ps
`default_nettype none
module eac_ack_ctrl_tb;
   typedef struct {
      logic [2:0] cs; logic sync; logic [5:0] wait_cnt; logic [3:0] asrt; logic [3:0] neg;
      logic lvl_en; logic edge_en; logic [1:0] insens; logic [10:0] low;
      int k; logic err; int gap;
   } eac_row_type;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic req_i = 1'h0;
   logic [2:0] cs_i = 3'h0;
   logic sync_i = 1'h0;
   logic [5:0] wait_cnt_i = 6'h01;
   logic [3:0] asrt_dly_i = 4'h0;
   logic [3:0] neg_dly_i = 4'h0;
   logic lvl_en_i = 1'h0;
   logic edge_en_i = 1'h0;
   logic [1:0] insens_i = 2'h0;
   logic [10:0] low_i = 11'h000;
   logic ack;
   logic busy_o, cs_active_o, stalled_o, done_o, bus_error_o;
   int bad_count = 0;
   int n_tests = 0;
   // cs sync wait asrt neg lvl edge insens low | cycles to answer, error, busy tail
   eac_row_type rows[12] = '{
      '{3'h1, 1'h0, 6'h03, 4'h1, 4'h2, 1'h0, 1'h0, 2'h0, 11'h000, 4, 1'h0, 2},
      '{3'h0, 1'h0, 6'h00, 4'h0, 4'h0, 1'h0, 1'h0, 2'h0, 11'h000, 1, 1'h0, 0},
      '{3'h2, 1'h1, 6'h02, 4'h0, 4'h0, 1'h1, 1'h0, 2'h0, 11'h014, 2, 1'h0, 0},
      '{3'h1, 1'h0, 6'h02, 4'h0, 4'h0, 1'h1, 1'h0, 2'h0, 11'h000, 4, 1'h0, 0},
      '{3'h1, 1'h0, 6'h02, 4'h1, 4'h2, 1'h1, 1'h0, 2'h3, 11'h000, 8, 1'h0, 2},
      '{3'h4, 1'h0, 6'h02, 4'h0, 4'h0, 1'h1, 1'h0, 2'h0, 11'h014, 2, 1'h0, 0},
      '{3'h5, 1'h0, 6'h3F, 4'h0, 4'h1, 1'h0, 1'h1, 2'h0, 11'h002, 4, 1'h0, 1},
      '{3'h5, 1'h0, 6'h3F, 4'h2, 4'h0, 1'h0, 1'h1, 2'h0, 11'h003, 7, 1'h0, 1},
      '{3'h3, 1'h0, 6'h02, 4'h0, 4'h0, 1'h1, 1'h1, 2'h0, 11'h014, 2, 1'h0, 0},
      '{3'h1, 1'h0, 6'h02, 4'h0, 4'h0, 1'h1, 1'h0, 2'h0, 11'h005, 8, 1'h0, 0},
      '{3'h1, 1'h0, 6'h02, 4'h0, 4'h1, 1'h1, 1'h0, 2'h0, 11'h7FF, 1024, 1'h1, 0},
      '{3'h5, 1'h0, 6'h3F, 4'h1, 4'h0, 1'h0, 1'h1, 2'h0, 11'h7FF, 1024, 1'h1, 0}
   };
   eac_ack_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .cs_index_i(cs_i),
      .sync_mode_i(sync_i), .wait_state_count_i(wait_cnt_i),
      .chip_select_assert_delay_i(asrt_dly_i),
      .chip_select_negate_delay_i(neg_dly_i), .ack_wait_enable_i(lvl_en_i),
      .ack_edge_mode_enable_i(edge_en_i), .ack_insensitivity_time_i(insens_i),
      .transfer_ack_input_i(ack), .busy_o(busy_o), .cs_active_o(cs_active_o),
      .stalled_o(stalled_o), .done_o(done_o), .bus_error_o(bus_error_o));
   eac_ack_dev dev (.clk_i(clk_i), .rst_i(rst_i), .cs_active_i(cs_active_o),
      .low_cyc_i(low_i), .ack_o(ack));
   // ----------------------------------------------------------------
   // clock, compares and closing
   // ----------------------------------------------------------------
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   task automatic final_report();
      $display("checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk_bit(input logic [4:0] got, input logic [4:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // ----------------------------------------------------------------
   // one access: request, count to the answer, then the busy tail
   // ----------------------------------------------------------------
   task automatic start(input eac_row_type r);
      @(posedge clk_i);
      cs_i <= r.cs;
      sync_i <= r.sync;
      wait_cnt_i <= r.wait_cnt;
      asrt_dly_i <= r.asrt;
      neg_dly_i <= r.neg;
      lvl_en_i <= r.lvl_en;
      edge_en_i <= r.edge_en;
      insens_i <= r.insens;
      low_i <= r.low;
      req_i <= 1'h1;
      @(posedge clk_i);
      req_i <= 1'h0;
   endtask
   task automatic run(input eac_row_type r);
      int k;
      int g;
      start(r);
      k = 0;
      while (k < 1100 && done_o !== 1'h1 && bus_error_o !== 1'h1) begin
         @(posedge clk_i);
         #1;
         k++;
      end
      chk_cnt(k, r.k);
      chk_bit({3'h0, bus_error_o, done_o}, {3'h0, r.err, ~r.err});
      if (r.err) begin
         chk_bit({3'h0, busy_o, cs_active_o}, 5'h00);
      end
      g = 0;
      while (g < 20 && busy_o === 1'h1) begin
         @(posedge clk_i);
         #1;
         g++;
      end
      chk_cnt(g, r.gap);
   endtask
   initial begin
      repeat (6000) @(posedge clk_i);
      bad_count++;
      final_report();
   end
   initial begin
      int d;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'h0;
      foreach (rows[i]) run(rows[i]);
      // a second request while busy is dropped, one answer only
      start(rows[0]);
      @(posedge clk_i);
      req_i <= 1'h1;
      @(posedge clk_i);
      req_i <= 1'h0;
      d = 0;
      repeat (30) begin
         @(posedge clk_i);
         #1;
         if (done_o === 1'h1) d++;
      end
      chk_cnt(d, 1);
      // stall seen, then reset in mid-access clears everything
      start(rows[9]);
      repeat (4) @(posedge clk_i);
      #1;
      chk_bit({4'h0, stalled_o}, 5'h01);
      @(posedge clk_i);
      rst_i <= 1'h1;
      @(posedge clk_i);
      rst_i <= 1'h0;
      #1;
      chk_bit({busy_o, cs_active_o, stalled_o, done_o, bus_error_o}, 5'h00);
      run(rows[3]);
      final_report();
   end
endmodule
`default_nettype wire
